// ===== sxe_pkg.sv
// package for the sixteen-bit serial io expander
package sxe_pkg;
  // ==========================================================
  // register pointer codes
  localparam logic [2:0] SXE_REG_PORT0_PIN_LEVELS  = 3'h0;
  localparam logic [2:0] SXE_REG_PORT1_PIN_LEVELS  = 3'h1;
  localparam logic [2:0] SXE_REG_PORT0_DRIVE_LATCH = 3'h2;
  localparam logic [2:0] SXE_REG_PORT1_DRIVE_LATCH = 3'h3;
  localparam logic [2:0] SXE_REG_PORT0_INVERT_MASK = 3'h4;
  localparam logic [2:0] SXE_REG_PORT1_INVERT_MASK = 3'h5;
  localparam logic [2:0] SXE_REG_PORT0_DIRECTION   = 3'h6;
  localparam logic [2:0] SXE_REG_PORT1_DIRECTION   = 3'h7;
  // ==========================================================
  // reset values
  localparam logic [7:0] SXE_RST_DRIVE_LATCH = 8'hff;
  localparam logic [7:0] SXE_RST_INVERT_MASK = 8'h00;
  localparam logic [7:0] SXE_RST_DIRECTION   = 8'hff;
  localparam logic [2:0] SXE_RST_POINTER     = 3'h0;
  // ==========================================================
  // address layout
  localparam logic [4:0] SXE_ADDR_FIXED      = 5'h1d;
  localparam int         SXE_POINTER_LSB     = 0;
  localparam int         SXE_POINTER_W       = 3;
  // ==========================================================
  // bus state
  typedef enum logic [2:0] {
    SXE_IDLE, SXE_ADDR, SXE_ADDR_ACK, SXE_RX, SXE_RX_ACK, SXE_TX, SXE_TX_ACK
  } sxe_state_t;
  typedef struct packed {
    logic [7:0] g0;
    logic [7:0] g1;
  } sxe_pair_t;
  typedef struct packed {
    logic [1:0]  scl_sync;
    logic [1:0]  sda_sync;
    logic        scl_prev;
    logic        sda_prev;
    logic [1:0]  strap_sync_low;
    logic [1:0]  strap_sync_high;
    logic [1:0]  rstn_sync;
    sxe_pair_t   pin_sync0;
    sxe_pair_t   pin_sync1;
    sxe_state_t  state;
    logic [3:0]  bit_cnt;
    logic [7:0]  shift;
    logic        is_read;
    logic        got_cmd;
    logic [2:0]  pointer;
    sxe_pair_t   drive_latch;
    sxe_pair_t   invert_mask;
    sxe_pair_t   direction;
    logic        sda_oe_n;
    sxe_pair_t   pin_out;
    sxe_pair_t   pin_oe_n;
  } sxe_regs_t;
endpackage

// ===== sxe_expander.sv
// two-wire slave expanding sixteen port pins in two groups
`timescale 1ns/1ps
// Functional notes
// - input pins: both drivers off, pin high impedance
// - output pins driven from the output latch bit
// - start is data falling while clock high; detected
// - address byte shifted in msb first, direction bit last
// - general call address ignored and not acknowledged
// - matching address acknowledged by data low during ninth pulse
// - one bit per clock pulse; data change while clock high is start or stop
// - stop is data rising while clock high; detected
// - bytes are eight bits plus acknowledge; transmitter releases data then
// - every received byte acknowledged when addressed as receiver
// - master nack on last read byte; device releases data line
// - address is fixed five bits plus two straps, 74 to 77 hex
// - direction bit one reads, zero writes
// - first written byte after address is the command byte
// - low three command bits select one of eight registers
// - pointer persists for later reads until new command
// - reset: latch and direction all ones, invert mask zeros
// - input registers report pin levels regardless of direction
// - writes to input registers discarded
// - latch reads return latch value; latch ignored on input pins
// - direction one means input, zero means output
// - invert bit one inverts reported input level
// - after each written data byte and each master-acked read byte, pointer toggles to other register of pair; a nacked read byte leaves it
// - low reset pin holds registers and bus machine in default state
module sxe_expander
  import sxe_pkg::*;
(
  // clock and reset
  input  wire logic      clk,
  input  wire logic      rst,
  // device pins
  input  wire logic      reset_n,
  input  wire logic      addr_strap_low,
  input  wire logic      addr_strap_high,
  // serial bus
  input  wire logic      scl_in,
  input  wire logic      sda_in,
  output logic           sda_out,
  output logic           sda_oe_n,
  // port pins
  input  wire sxe_pair_t pins_in,
  output sxe_pair_t      pins_out,
  output sxe_pair_t      pins_oe_n
);
  sxe_regs_t r_r;
  sxe_regs_t r_nxt;
  // ==========================================================
  // next state
  always_comb begin
    logic       scl;
    logic       sda;
    logic       rise;
    logic       fall;
    logic       start;
    logic       stop;
    logic [6:0] own;
    logic [7:0] byte_in;
    logic [7:0] rd_val;
    logic [2:0] sel;
    sxe_pair_t  levels;
    r_nxt = r_r;
    scl = r_r.scl_sync[1];
    sda = r_r.sda_sync[1];
    rise = scl & ~r_r.scl_prev;
    fall = ~scl & r_r.scl_prev;
    start = scl & r_r.scl_prev & r_r.sda_prev & ~sda;
    stop = scl & r_r.scl_prev & ~r_r.sda_prev & sda;
    own = {SXE_ADDR_FIXED, r_r.strap_sync_high[1], r_r.strap_sync_low[1]};
    byte_in = {r_r.shift[6:0], sda};
    levels.g0 = r_r.pin_sync1.g0 ^ r_r.invert_mask.g0;
    levels.g1 = r_r.pin_sync1.g1 ^ r_r.invert_mask.g1;
    rd_val = 8'h00;
    // next read byte comes from the partner register once a byte is acked
    sel = r_r.pointer;
    if (r_r.state == SXE_TX_ACK) begin
      sel = r_r.pointer ^ 3'h1;
    end
    case (sel)
      SXE_REG_PORT0_PIN_LEVELS:  rd_val = levels.g0;
      SXE_REG_PORT1_PIN_LEVELS:  rd_val = levels.g1;
      SXE_REG_PORT0_DRIVE_LATCH: rd_val = r_r.drive_latch.g0;
      SXE_REG_PORT1_DRIVE_LATCH: rd_val = r_r.drive_latch.g1;
      SXE_REG_PORT0_INVERT_MASK: rd_val = r_r.invert_mask.g0;
      SXE_REG_PORT1_INVERT_MASK: rd_val = r_r.invert_mask.g1;
      SXE_REG_PORT0_DIRECTION:   rd_val = r_r.direction.g0;
      default:                   rd_val = r_r.direction.g1;
    endcase
    r_nxt.scl_sync = {r_r.scl_sync[0], scl_in};
    r_nxt.sda_sync = {r_r.sda_sync[0], sda_in};
    r_nxt.scl_prev = scl;
    r_nxt.sda_prev = sda;
    r_nxt.strap_sync_low = {r_r.strap_sync_low[0], addr_strap_low};
    r_nxt.strap_sync_high = {r_r.strap_sync_high[0], addr_strap_high};
    r_nxt.rstn_sync = {r_r.rstn_sync[0], reset_n};
    r_nxt.pin_sync0 = pins_in;
    r_nxt.pin_sync1 = r_r.pin_sync0;
    if (start) begin
      r_nxt.state = SXE_ADDR;
      r_nxt.bit_cnt = 4'h0;
      r_nxt.sda_oe_n = 1'b1;
    end else if (stop) begin
      r_nxt.state = SXE_IDLE;
      r_nxt.sda_oe_n = 1'b1;
    end else begin
      case (r_r.state)
        SXE_ADDR: begin
          if (rise) begin
            r_nxt.shift = byte_in;
            r_nxt.bit_cnt = r_r.bit_cnt + 4'h1;
          end
          if (fall && r_r.bit_cnt == 4'h8) begin
            // general call is zero address, never equal to own
            if (r_r.shift[7:1] == own) begin
              r_nxt.is_read = r_r.shift[0];
              r_nxt.got_cmd = 1'b0;
              r_nxt.sda_oe_n = 1'b0;
              r_nxt.state = SXE_ADDR_ACK;
            end else begin
              r_nxt.state = SXE_IDLE;
            end
          end
        end
        SXE_ADDR_ACK: begin
          if (fall) begin
            r_nxt.bit_cnt = 4'h0;
            if (r_r.is_read) begin
              r_nxt.shift = rd_val;
              r_nxt.sda_oe_n = rd_val[7];
              r_nxt.state = SXE_TX;
            end else begin
              r_nxt.sda_oe_n = 1'b1;
              r_nxt.state = SXE_RX;
            end
          end
        end
        SXE_RX: begin
          if (rise) begin
            r_nxt.shift = byte_in;
            r_nxt.bit_cnt = r_r.bit_cnt + 4'h1;
          end
          if (fall && r_r.bit_cnt == 4'h8) begin
            r_nxt.sda_oe_n = 1'b0;
            r_nxt.state = SXE_RX_ACK;
            if (!r_r.got_cmd) begin
              r_nxt.pointer = r_r.shift[SXE_POINTER_LSB +: SXE_POINTER_W];
              r_nxt.got_cmd = 1'b1;
            end else begin
              case (r_r.pointer)
                SXE_REG_PORT0_DRIVE_LATCH: r_nxt.drive_latch.g0 = r_r.shift;
                SXE_REG_PORT1_DRIVE_LATCH: r_nxt.drive_latch.g1 = r_r.shift;
                SXE_REG_PORT0_INVERT_MASK: r_nxt.invert_mask.g0 = r_r.shift;
                SXE_REG_PORT1_INVERT_MASK: r_nxt.invert_mask.g1 = r_r.shift;
                SXE_REG_PORT0_DIRECTION:   r_nxt.direction.g0 = r_r.shift;
                SXE_REG_PORT1_DIRECTION:   r_nxt.direction.g1 = r_r.shift;
                default:                   r_nxt.pointer = r_r.pointer;
              endcase
              r_nxt.pointer = r_r.pointer ^ 3'h1;
            end
          end
        end
        SXE_RX_ACK: begin
          if (fall) begin
            r_nxt.sda_oe_n = 1'b1;
            r_nxt.bit_cnt = 4'h0;
            r_nxt.state = SXE_RX;
          end
        end
        SXE_TX: begin
          if (rise) begin
            r_nxt.bit_cnt = r_r.bit_cnt + 4'h1;
          end
          if (fall) begin
            if (r_r.bit_cnt == 4'h8) begin
              r_nxt.sda_oe_n = 1'b1;
              r_nxt.state = SXE_TX_ACK;
            end else begin
              r_nxt.shift = {r_r.shift[6:0], 1'b0};
              r_nxt.sda_oe_n = r_r.shift[6];
            end
          end
        end
        SXE_TX_ACK: begin
          if (rise) begin
            // master nack ends the read and the line stays released
            r_nxt.is_read = ~sda;
          end
          if (fall) begin
            r_nxt.bit_cnt = 4'h0;
            if (r_r.is_read) begin
              r_nxt.pointer = r_r.pointer ^ 3'h1;
              r_nxt.shift = rd_val;
              r_nxt.sda_oe_n = rd_val[7];
              r_nxt.state = SXE_TX;
            end else begin
              r_nxt.state = SXE_IDLE;
            end
          end
        end
        default: begin
          r_nxt.sda_oe_n = 1'b1;
        end
      endcase
    end
    r_nxt.pin_oe_n = r_r.direction;
    r_nxt.pin_out = r_r.drive_latch;
    if (!r_r.rstn_sync[1]) begin
      r_nxt.state = SXE_IDLE;
      r_nxt.sda_oe_n = 1'b1;
      r_nxt.pointer = SXE_RST_POINTER;
      r_nxt.drive_latch = {SXE_RST_DRIVE_LATCH, SXE_RST_DRIVE_LATCH};
      r_nxt.invert_mask = {SXE_RST_INVERT_MASK, SXE_RST_INVERT_MASK};
      r_nxt.direction = {SXE_RST_DIRECTION, SXE_RST_DIRECTION};
    end
  end
  // ==========================================================
  // state register
  always_ff @(posedge clk) begin
    if (rst) begin
      r_r <= '0;
      r_r.scl_sync <= 2'h3;
      r_r.sda_sync <= 2'h3;
      r_r.scl_prev <= 1'b1;
      r_r.sda_prev <= 1'b1;
      r_r.rstn_sync <= 2'h3;
      r_r.state <= SXE_IDLE;
      r_r.sda_oe_n <= 1'b1;
      r_r.pointer <= SXE_RST_POINTER;
      r_r.drive_latch <= {SXE_RST_DRIVE_LATCH, SXE_RST_DRIVE_LATCH};
      r_r.invert_mask <= {SXE_RST_INVERT_MASK, SXE_RST_INVERT_MASK};
      r_r.direction <= {SXE_RST_DIRECTION, SXE_RST_DIRECTION};
      r_r.pin_out <= {SXE_RST_DRIVE_LATCH, SXE_RST_DRIVE_LATCH};
      r_r.pin_oe_n <= {SXE_RST_DIRECTION, SXE_RST_DIRECTION};
    end else begin
      r_r <= r_nxt;
    end
  end
  assign sda_out = 1'b0;
  assign sda_oe_n = r_r.sda_oe_n;
  assign pins_out = r_r.pin_out;
  assign pins_oe_n = r_r.pin_oe_n;
endmodule

// ===== sxe_assertions.sv
// assertions for the serial io expander
`timescale 1ns/1ps
module sxe_checker
  import sxe_pkg::*;
(
  // clock and resets
  input wire logic      clk,
  input wire logic      rst,
  input wire logic      reset_n,
  // bus and pins
  input wire logic      scl_in,
  input wire logic      sda_in,
  input wire logic      sda_out,
  input wire logic      sda_oe_n,
  input wire sxe_pair_t pins_out,
  input wire sxe_pair_t pins_oe_n
);
  // ======
  // properties
  default clocking @(posedge clk); endclocking
  default disable iff (rst || !reset_n);
  chk_rst_defaults:
    assert property ($fell(rst) |-> sda_oe_n && pins_out == 16'hffff && pins_oe_n == 16'hffff)
      else $error("outputs not at reset values");
  chk_sda_clk_low:
    assert property ($changed(sda_oe_n) |-> !scl_in)
      else $error("data line moved while clock high");
  chk_ack_timing:
    assert property ($fell(sda_oe_n) |-> !scl_in && $past(scl_in, 6))
      else $error("data driven too late after clock fall");
  chk_pin_reset:
    assert property (disable iff (rst) !reset_n [*8] |-> sda_oe_n && pins_oe_n == 16'hffff)
      else $error("reset pin low but state not default");
  chk_dir_change:
    assert property ($changed(pins_oe_n) |-> !scl_in)
      else $error("direction changed while clock high");
  chk_latch_change:
    assert property ($changed(pins_out) |-> !scl_in)
      else $error("pin drive changed while clock high");
  chk_stop_idle:
    assert property (scl_in && $rose(sda_in) |=> sda_oe_n [*8])
      else $error("data pulled after stop");
  chk_open_drain:
    assert property (!sda_oe_n |-> sda_out == 1'b0)
      else $error("data line driven high");
endmodule
bind sxe_expander sxe_checker i_chk (.clk, .rst, .reset_n, .scl_in, .sda_in, .sda_out,
  .sda_oe_n, .pins_out, .pins_oe_n);

// ===== sxe_master.sv
// bus master model for the serial io expander
`timescale 1ns/1ps
module sxe_master (
  // serial bus
  output logic     scl,
  output logic     sda_m,
  input wire logic sda
);
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
  end
  task automatic start;
    #31.25 sda_m = 1'b0;
    #31.25 scl = 1'b0;
  endtask
  task automatic bit_io(input logic b, output logic r);
    #31.25 sda_m = b;
    #31.25 scl = 1'b1;
    #31.25 r = sda;
    #31.25 scl = 1'b0;
  endtask
  task automatic xfer(input logic [7:0] d, input logic ak, output logic [7:0] q,
                      output logic a);
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(ak, a);
  endtask
  task automatic stop;
    #31.25 sda_m = 1'b0;
    #31.25 scl = 1'b1;
    #31.25 sda_m = 1'b1;
    #62.5;
  endtask
endmodule

// ===== tb.sv
// self-checking bench for the serial io expander
`timescale 1ns/1ps
module tb;
  import sxe_pkg::*;
  typedef struct packed {
    logic [2:0]  p;
    logic [15:0] w;
    logic [15:0] e;
  } sxe_row_t;
  // ======
  // wiring
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        reset_n = 1'b1;
  logic [1:0]  strap = 2'b10;
  logic [15:0] ext = 16'h1234;
  logic        scl;
  logic        sda_m;
  logic        sda_out;
  logic        sda_oe_n;
  wire logic   sda;
  sxe_pair_t   pins_in;
  sxe_pair_t   pins_out;
  sxe_pair_t   pins_oe_n;
  int          err_total = 0;
  int          n_compared = 0;
  sxe_row_t    rows [4] = '{'{3'h2, 16'ha55a, 16'ha55a}, '{3'h5, 16'h0ff0, 16'h0ff0},
                            '{3'h6, 16'h00ff, 16'h00ff}, '{3'h0, 16'h1122, 16'h553b}};
  always #2.5 clk = ~clk;
  assign sda = sda_m & (sda_oe_n | sda_out);
  assign pins_in = (pins_out & ~pins_oe_n) | (ext & pins_oe_n);
  sxe_expander i_dut (.clk, .rst, .reset_n, .addr_strap_low(strap[0]),
    .addr_strap_high(strap[1]), .scl_in(scl), .sda_in(sda), .sda_out, .sda_oe_n,
    .pins_in, .pins_out, .pins_oe_n);
  sxe_master i_mst (.scl, .sda_m, .sda);
  // ======
  // tasks
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
    n_compared++;
    if (s !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [2:0] p, input int n, input logic [15:0] d);
    logic [7:0] q;
    logic       a;
    i_mst.start();
    i_mst.xfer({7'h74 | 7'(strap), 1'b0}, 1'b1, q, a);
    chk("address ack", 16'h0, {15'h0, a});
    i_mst.xfer({5'h0, p}, 1'b1, q, a);
    chk("command ack", 16'h0, {15'h0, a});
    for (int i = 0; i < n; i++) begin
      i_mst.xfer(i ? d[7:0] : d[15:8], 1'b1, q, a);
      chk("data ack", 16'h0, {15'h0, a});
    end
    i_mst.stop();
  endtask
  task automatic rd(input logic [2:0] p, input logic [15:0] e);
    logic [15:0] q;
    logic        a;
    wr(p, 0, 16'h0);
    i_mst.start();
    i_mst.xfer({7'h74 | 7'(strap), 1'b1}, 1'b1, q[7:0], a);
    chk("read address ack", 16'h0, {15'h0, a});
    i_mst.xfer(8'hff, 1'b0, q[15:8], a);
    i_mst.xfer(8'hff, 1'b1, q[7:0], a);
    i_mst.stop();
    chk("read data", e, q);
  endtask
  task automatic conclude;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // ======
  // sequence
  initial begin
    repeat (60000) @(posedge clk);
    err_total++;
    conclude();
  end
  initial begin
    logic [7:0] q;
    logic       a;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    foreach (rows[i]) begin
      wr(rows[i].p, 2, rows[i].w);
      rd(rows[i].p, rows[i].e);
      $display("row %0d done", i);
    end
    chk("pin drive", 16'ha55a, pins_out);
    chk("pin direction", 16'h00ff, pins_oe_n);
    for (int i = 0; i < 2; i++) begin
      i_mst.start();
      i_mst.xfer(i ? 8'he8 : 8'h00, 1'b1, q, a);
      i_mst.stop();
      chk("foreign address ack", 16'h1, {15'h0, a});
    end
    $display("address test done");
    @(posedge clk) reset_n <= 1'b0;
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk);
    chk("pin direction", 16'hffff, pins_oe_n);
    rd(3'h2, 16'hffff);
    rd(3'h4, 16'h0000);
    rd(3'h6, 16'hffff);
    $display("reset pin test done");
    conclude();
  end
endmodule
